// >>> rtl/eth_rx_dma_defs.svh
// Offsets, field positions and timing counts of the receive slave DMA
`ifndef ETH_RX_DMA_DEFS_SVH
`define ETH_RX_DMA_DEFS_SVH

// Register indices, byte address is four times the index
`define IDX_RCV_CFG    12'h003
`define IDX_RCV_EVT    12'h004
`define IDX_BUF_CFG    12'h00B
`define IDX_BUF_EVT    12'h00C
`define IDX_MISSED     12'h010
`define IDX_BUS_CTL    12'h017
`define IDX_CHAN_SEL   12'h024
`define IDX_FRAME_SOF  12'h026
`define IDX_FRAME_CNT  12'h028
`define IDX_BYTE_CNT   12'h02A

// Field positions
`define CFG_DMA_ONLY_BIT  9
`define CFG_AUTO_DMA_BIT  10
`define BUS_DMA_RST_BIT   6
`define BUS_BURST_BIT     11
`define BUS_SIZE_BIT      13
`define BUF_CFG_IE_BIT    7
`define BUF_EVT_FLAG_BIT  7

// Reset values
`define REG_RESET         16'h0000

// Host buffer offset masks
`define MASK_16K          16'h3FFF
`define MASK_64K          16'hFFFF
`define BOUNDARY_BIT      17

// Timing
`define CLK_MHZ           50
`define BURST_ON_US       28000
`define BURST_OFF_US      1300
`define BURST_ON_CYC      (`BURST_ON_US * `CLK_MHZ)
`define BURST_OFF_CYC     (`BURST_OFF_US * `CLK_MHZ)

`endif

// >>> rtl/eth_rx_dma_pkg.sv
// Types used by the device end of the receive slave DMA
package eth_rx_dma_pkg;
	typedef enum logic [1:0] {
		ING_IDLE = 2'b00,
		ING_LEN  = 2'b01,
		ING_DATA = 2'b10,
		ING_DROP = 2'b11
	} ingress_state_t;

	typedef enum logic {
		SND_IDLE = 1'b0,
		SND_XFER = 1'b1
	} send_state_t;
endpackage : eth_rx_dma_pkg

// >>> rtl/dma_link_if.sv
// Request/acknowledge pin pairs and data word between device and host DMA
`timescale 1ns/10ps
interface dma_link_if;
	logic [2:0]  dma_request_pin;
	logic [2:0]  dma_acknowledge_pin_n;
	logic [15:0] dma_data;

	modport device (output dma_request_pin, output dma_data, input dma_acknowledge_pin_n);
	modport host   (input dma_request_pin, input dma_data, output dma_acknowledge_pin_n);
endinterface : dma_link_if

// >>> rtl/eth_rx_dma_host.sv
// Host DMA controller end: answers requests and writes words to host memory
`timescale 1ns/10ps
`include "eth_rx_dma_defs.svh"
module eth_rx_dma_host (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// Channel programming
	input  wire logic        i_enable,
	input  wire logic [1:0]  i_channel,
	input  wire logic [23:0] i_base,
	input  wire logic        i_big,
	// Host memory write port
	output logic             o_mem_we,
	output logic [23:0]      o_mem_addr,
	output logic [15:0]      o_mem_data,
	output logic             o_boundary_fault,
	// Link
	dma_link_if.host         link
);
	logic [2:0]  ack_q;
	logic        gap_q;
	logic [15:0] off_q;
	logic [15:0] mask;
	logic [23:0] last;
	logic        ok;

	// Buffer end and 128K check; a crossing buffer disables the channel
	assign mask = i_big ? `MASK_64K : `MASK_16K;
	assign last = i_base + {8'h00, mask};
	assign o_boundary_fault = i_base[23:`BOUNDARY_BIT] != last[23:`BOUNDARY_BIT];
	assign ok = i_enable && !o_boundary_fault && (i_channel != 2'h3);
	assign link.dma_acknowledge_pin_n = ~ack_q;

	// One acknowledge cycle, then two idle cycles so device data settles
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ack_q <= 3'h0;
			gap_q <= 1'b0;
		end else begin
			gap_q <= |ack_q;
			ack_q <= 3'h0;
			if (ok && !gap_q && !(|ack_q) && link.dma_request_pin[i_channel]) begin
				ack_q[i_channel] <= 1'b1;
			end
		end
	end

	// Word captured on the acknowledge edge; offset wraps with the buffer
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_mem_we   <= 1'b0;
			o_mem_addr <= 24'h000000;
			o_mem_data <= 16'h0000;
			off_q      <= 16'h0000;
		end else begin
			o_mem_we <= 1'b0;
			if (!i_enable) begin
				off_q <= 16'h0000;
			end else if (|(ack_q & link.dma_request_pin)) begin
				// Request still up under the acknowledge: the word is written
				o_mem_we   <= 1'b1;
				o_mem_addr <= i_base + {8'h00, off_q};
				o_mem_data <= link.dma_data;
				off_q      <= (off_q + 16'h0002) & mask;
			end
		end
	end
endmodule : eth_rx_dma_host

// >>> rtl/eth_rx_dma_device.sv
// Device end: on-chip frame RAM, register file on APB, slave DMA sender
`timescale 1ns/10ps
`include "eth_rx_dma_defs.svh"
module eth_rx_dma_device #(
	parameter int P_RAM_WORDS     = 1024,
	parameter int P_BURST_ON_CYC  = `BURST_ON_CYC,
	parameter int P_BURST_OFF_CYC = `BURST_OFF_CYC
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Receiver side, frames already filtered
	input  wire logic        i_rx_start,
	input  wire logic [15:0] i_rx_len,
	input  wire logic [15:0] i_rx_status,
	input  wire logic        i_rx_valid,
	input  wire logic [15:0] i_rx_data,
	output logic             o_rx_ready,
	input  wire logic [15:0] i_rx_event_word,
	// Interrupt
	output logic             o_irq,
	// Link
	dma_link_if.device       link
);
	localparam int AW = $clog2(P_RAM_WORDS);

	logic [15:0] ram [P_RAM_WORDS];
	logic [15:0] cfg_q, bus_control_reg_q, buffer_config_reg_q, chan_q, sof_q, bcnt_q, miss_q;
	logic [11:0] fcnt_q;
	logic        flag_q;
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0]   used_q;
	logic [15:0]   pend_q, rem_q;
	eth_rx_dma_pkg::ingress_state_t ing_q;
	eth_rx_dma_pkg::send_state_t    snd_q;
	logic [15:0] tail_q, start_q, fend_q, rel_q, cend_q, left_q, real_q;
	logic        active_q, newer_q, gap_q;
	logic [20:0] bcyc_q;
	logic [15:0] data_q;

	// Length in words of a stored frame, header words included
	function automatic logic [15:0] frame_words(input logic [15:0] len);
		frame_words = 16'h0002 + {1'b0, len[15:1]} + {15'h0000, len[0]};
	endfunction : frame_words

	// Host buffer offset mask for the selected size
	function automatic logic [15:0] buf_mask(input logic big);
		buf_mask = big ? `MASK_64K : `MASK_16K;
	endfunction : buf_mask

	logic wr_en, rd_en, big, dma_on, dma_rst, rd_fcnt, rd_bcnt, rd_miss, rd_bevt;
	logic req, ack, done, missed, ram_we, ram_rd;
	logic [15:0] ram_wd, hlen, hwords, htotal;
	logic [16:0] hfree, hneed;

	assign wr_en   = i_psel && i_penable && i_pwrite;
	assign rd_en   = i_psel && i_penable && !i_pwrite;
	assign big     = bus_control_reg_q[`BUS_SIZE_BIT];
	// Auto-switch alone is not served; DMA-only overrides it
	assign dma_on  = cfg_q[`CFG_DMA_ONLY_BIT];
	assign dma_rst = wr_en && (i_paddr == {`IDX_BUS_CTL, 2'b00}) && i_pwdata[`BUS_DMA_RST_BIT];
	assign rd_fcnt = rd_en && (i_paddr == {`IDX_FRAME_CNT, 2'b00});
	assign rd_bcnt = rd_en && (i_paddr == {`IDX_BYTE_CNT, 2'b00});
	assign rd_miss = rd_en && (i_paddr == {`IDX_MISSED, 2'b00});
	assign rd_bevt = rd_en && (i_paddr == {`IDX_BUF_EVT, 2'b00});
	assign o_pready = 1'b1;
	assign o_irq    = flag_q && buffer_config_reg_q[`BUF_CFG_IE_BIT];

	// Read mux and unmapped-address error
	always_comb begin
		o_prdata  = 32'h00000000;
		o_pslverr = 1'b0;
		if (i_paddr == {`IDX_RCV_CFG, 2'b00}) begin
			o_prdata[15:0] = cfg_q;
		end else if (i_paddr == {`IDX_RCV_EVT, 2'b00}) begin
			o_prdata[15:0] = dma_on ? 16'h0000 : i_rx_event_word;
		end else if (i_paddr == {`IDX_BUF_CFG, 2'b00}) begin
			o_prdata[15:0] = buffer_config_reg_q;
		end else if (i_paddr == {`IDX_BUF_EVT, 2'b00}) begin
			o_prdata[`BUF_EVT_FLAG_BIT] = flag_q;
		end else if (i_paddr == {`IDX_MISSED, 2'b00}) begin
			o_prdata[15:0] = miss_q;
		end else if (i_paddr == {`IDX_BUS_CTL, 2'b00}) begin
			o_prdata[15:0] = bus_control_reg_q;
		end else if (i_paddr == {`IDX_CHAN_SEL, 2'b00}) begin
			o_prdata[15:0] = chan_q;
		end else if (i_paddr == {`IDX_FRAME_SOF, 2'b00}) begin
			o_prdata[15:0] = sof_q;
		end else if (i_paddr == {`IDX_FRAME_CNT, 2'b00}) begin
			o_prdata[11:0] = fcnt_q;
		end else if (i_paddr == {`IDX_BYTE_CNT, 2'b00}) begin
			o_prdata[15:0] = bcnt_q;
		end else begin
			o_pslverr = i_psel && i_penable;
		end
	end

	// Software-written control; DMA reset bit is a pulse and reads zero
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			cfg_q    <= `REG_RESET;
			bus_control_reg_q <= `REG_RESET;
			buffer_config_reg_q <= `REG_RESET;
			chan_q   <= `REG_RESET;
		end else if (wr_en) begin
			if (i_paddr == {`IDX_RCV_CFG, 2'b00}) begin
				cfg_q <= i_pwdata[15:0];
			end else if (i_paddr == {`IDX_BUS_CTL, 2'b00}) begin
				bus_control_reg_q <= i_pwdata[15:0] & ~(16'h0001 << `BUS_DMA_RST_BIT);
			end else if (i_paddr == {`IDX_BUF_CFG, 2'b00}) begin
				buffer_config_reg_q <= i_pwdata[15:0];
			end else if (i_paddr == {`IDX_CHAN_SEL, 2'b00}) begin
				chan_q <= i_pwdata[15:0];
			end
		end
	end

	// Read-clear counters; an update in the read cycle survives the clear
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			fcnt_q <= 12'h000;
			bcnt_q <= 16'h0000;
			miss_q <= 16'h0000;
			flag_q <= 1'b0;
			sof_q  <= 16'h0000;
		end else begin
			fcnt_q <= (rd_fcnt ? 12'h000 : fcnt_q) + {11'h000, done};
			bcnt_q <= (rd_bcnt ? 16'h0000 : bcnt_q) + (ack ? 16'h0002 : 16'h0000);
			miss_q <= (rd_miss ? 16'h0000 : miss_q) + {15'h0000, missed};
			// Flag tracks the count, so reading the event register leaves it
			flag_q <= ((rd_fcnt ? 12'h000 : fcnt_q) + {11'h000, done}) != 12'h000;
			if (done) begin
				sof_q <= start_q;
			end
		end
	end

	// Frame ingress into on-chip RAM with a space check at frame start
	assign hneed      = {1'b0, frame_words(i_rx_len)};
	assign o_rx_ready = (ing_q == eth_rx_dma_pkg::ING_DATA) || (ing_q == eth_rx_dma_pkg::ING_DROP);
	always_comb begin
		ram_we = 1'b0;
		ram_wd = i_rx_data;
		missed = 1'b0;
		case (ing_q)
			eth_rx_dma_pkg::ING_IDLE: begin
				// Zero-length starts are refused, so they neither store nor count
				if (i_rx_start && i_rx_len != 16'h0000) begin
					missed = ({{(16 - AW){1'b0}}, P_RAM_WORDS[AW:0] - used_q} < hneed);
					ram_we = !missed;
					ram_wd = i_rx_status;
				end
			end
			eth_rx_dma_pkg::ING_LEN: begin
				ram_we = 1'b1;
				ram_wd = rem_q;
			end
			eth_rx_dma_pkg::ING_DATA: ram_we = i_rx_valid;
			default: ram_we = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ing_q <= eth_rx_dma_pkg::ING_IDLE;
			rem_q <= 16'h0000;
			wr_q  <= '0;
		end else begin
			if (ram_we) begin
				wr_q <= wr_q + 1'b1;
			end
			case (ing_q)
				eth_rx_dma_pkg::ING_IDLE: begin
					if (i_rx_start && i_rx_len != 16'h0000) begin
						rem_q <= missed ? frame_words(i_rx_len) - 16'h0002 : i_rx_len;
						ing_q <= missed ? eth_rx_dma_pkg::ING_DROP : eth_rx_dma_pkg::ING_LEN;
					end
				end
				eth_rx_dma_pkg::ING_LEN: begin
					rem_q <= frame_words(rem_q) - 16'h0002;
					ing_q <= eth_rx_dma_pkg::ING_DATA;
				end
				default: begin
					if (i_rx_valid) begin
						rem_q <= rem_q - 16'h0001;
						if (rem_q == 16'h0001) begin
							ing_q <= eth_rx_dma_pkg::ING_IDLE;
						end
					end
				end
			endcase
		end
	end

	// RAM write port and registered read toward the link
	always_ff @(posedge i_clock) begin
		if (ram_we) begin
			ram[wr_q] <= ram_wd;
		end
		data_q <= ram[rd_q];
	end
	assign link.dma_data = data_q;

	// Stored word and complete-frame bookkeeping; a frame is queued on its last word
	assign ram_rd = ack && (real_q != 16'h0000);
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			used_q <= '0;
			pend_q <= 16'h0000;
		end else begin
			used_q <= used_q + {{AW{1'b0}}, ram_we} - {{AW{1'b0}}, ram_rd};
			pend_q <= pend_q + {15'h0000, ram_we && ing_q == eth_rx_dma_pkg::ING_DATA && rem_q == 16'h0001}
			          - {15'h0000, done};
		end
	end

	// Next frame header and host room left before committed space
	assign hlen   = ram[rd_q + 1'b1];
	assign hwords = frame_words(hlen);
	assign htotal = hwords + {15'h0000, hwords[0]};
	// Equal offsets while space is committed mean the ring has wrapped: no room
	assign hfree  = {1'b0, (rel_q - tail_q) & buf_mask(big)};

	// Request runs the whole frame, or in timed bursts when enabled
	assign req  = (snd_q == eth_rx_dma_pkg::SND_XFER) && !gap_q && (chan_q < 16'h0003);
	assign ack  = req && !link.dma_acknowledge_pin_n[chan_q[1:0]];
	assign done = ack && (left_q == 16'h0001);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			link.dma_request_pin[i] = req && (chan_q[1:0] == i[1:0]);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn || snd_q != eth_rx_dma_pkg::SND_XFER || !bus_control_reg_q[`BUS_BURST_BIT]) begin
			bcyc_q <= 21'h000000;
			gap_q  <= 1'b0;
		end else if (bcyc_q == (gap_q ? P_BURST_OFF_CYC[20:0] : P_BURST_ON_CYC[20:0]) - 21'h000001) begin
			// Pause never starts right after a word, so a drop after a word ends a frame
			if (gap_q || !ack) begin
				bcyc_q <= 21'h000000;
				gap_q  <= !gap_q;
			end
		end else begin
			bcyc_q <= bcyc_q + 21'h000001;
		end
	end

	// Sender: status, length, data, then a pad word when the word count is odd, for 32-bit alignment
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			snd_q   <= eth_rx_dma_pkg::SND_IDLE;
			rd_q    <= '0;
			left_q  <= 16'h0000;
			real_q  <= 16'h0000;
			start_q <= 16'h0000;
			tail_q  <= 16'h0000;
			fend_q  <= 16'h0000;
		end else begin
			case (snd_q)
				eth_rx_dma_pkg::SND_IDLE: begin
					if (dma_rst) begin
						tail_q <= 16'h0000;
						fend_q <= 16'h0000;
					end else if (dma_on && pend_q != 16'h0000
					             && !(active_q && {htotal, 1'b0} > hfree)) begin
						snd_q   <= eth_rx_dma_pkg::SND_XFER;
						left_q  <= htotal;
						real_q  <= hwords;
						start_q <= tail_q;
					end
				end
				default: begin
					if (ack) begin
						left_q <= left_q - 16'h0001;
						tail_q <= (tail_q + 16'h0002) & buf_mask(big);
						if (ram_rd) begin
							real_q <= real_q - 16'h0001;
							rd_q   <= rd_q + 1'b1;
						end
						if (done) begin
							fend_q <= (tail_q + 16'h0002) & buf_mask(big);
							snd_q  <= eth_rx_dma_pkg::SND_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Commitment: first count read commits, reread, skip or reset releases
	always_ff @(posedge i_clock) begin
		if (!i_rstn || dma_rst) begin
			active_q <= 1'b0;
			newer_q  <= 1'b0;
			rel_q    <= 16'h0000;
			cend_q   <= 16'h0000;
		end else begin
			if (done && active_q) begin
				newer_q <= 1'b1;
			end
			if (rd_fcnt && active_q) begin
				active_q <= 1'b0;
				rel_q    <= cend_q;
			end else if (rd_bevt && active_q && flag_q && newer_q) begin
				active_q <= 1'b0;
				rel_q    <= cend_q;
			end else if (rd_fcnt && fcnt_q != 12'h000) begin
				active_q <= 1'b1;
				newer_q  <= 1'b0;
				cend_q   <= fend_q;
			end
		end
	end
endmodule : eth_rx_dma_device

// >>> verif/eth_rx_dma_link_sva.sv
// Assertions on the request/acknowledge link between the two DMA ends
`timescale 1ns/10ps
module eth_rx_dma_link_sva (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rstn,
	// Link signals
	input  wire logic [2:0]  dma_request_pin,
	input  wire logic [2:0]  dma_acknowledge_pin_n,
	input  wire logic [15:0] dma_data
);
	logic moved;
	logic any_req;
	logic mv_odd_q;

	// A word moves where a pin pair is requested and acknowledged at once
	assign moved   = |(dma_request_pin & ~dma_acknowledge_pin_n);
	assign any_req = |dma_request_pin;

	// Word parity, frames must end on an even word count
	always_ff @(posedge i_clock) begin
		if (!i_rstn)
			mv_odd_q <= 1'b0;
		else if (moved)
			mv_odd_q <= ~mv_odd_q;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	sequence s_move;
		moved;
	endsequence
	// Host rests two cycles after each word
	sequence s_rest;
		(&dma_acknowledge_pin_n)[*2];
	endsequence
	// Burst pause, then the request comes back
	sequence s_pause;
		(!any_req)[*8] ##[1:12] any_req;
	endsequence

	AST_ONE_PAIR: assert property ($onehot0(dma_request_pin))
		else $error("more than one request pin high");
	AST_CHAN_KEEP: assert property ((any_req && $past(any_req)) |->
		(dma_request_pin == $past(dma_request_pin)))
		else $error("request moved to another pin");
	AST_ACK_FOLLOWS_REQ: assert property ((|(~dma_acknowledge_pin_n)) |->
		((~dma_acknowledge_pin_n & ~$past(dma_request_pin)) == 3'b000))
		else $error("acknowledge without request");
	AST_HOST_REST: assert property (s_move |=> s_rest)
		else $error("host did not rest after a word");
	AST_ACK_PROMPT: assert property ($rose(any_req) |-> ##[1:4] moved)
		else $error("request not answered");
	AST_REQ_HELD: assert property ($rose(any_req) |-> any_req[*2])
		else $error("request pulse too short");
	AST_BURST_PAUSE: assert property (($fell(any_req) && !$past(moved)) |-> ##1 s_pause)
		else $error("burst pause length wrong");
	AST_EVEN_WORDS: assert property (($fell(any_req) && $past(moved)) |-> !mv_odd_q)
		else $error("frame ended on odd word count");
endmodule : eth_rx_dma_link_sva

// >>> verif/ethernet_receive_slave_dma_tb.sv
// Self-checking bench: device and host DMA ends joined over the link
`timescale 1ns/10ps
`include "eth_rx_dma_defs.svh"
module ethernet_receive_slave_dma_tb;
	localparam logic [23:0] BASE    = 24'h020000;
	localparam logic [11:0] A_RCFG  = `IDX_RCV_CFG << 2;
	localparam logic [11:0] A_REVT  = `IDX_RCV_EVT << 2;
	localparam logic [11:0] A_BCFG  = `IDX_BUF_CFG << 2;
	localparam logic [11:0] A_BEVT  = `IDX_BUF_EVT << 2;
	localparam logic [11:0] A_MISS  = `IDX_MISSED << 2;
	localparam logic [11:0] A_BUS   = `IDX_BUS_CTL << 2;
	localparam logic [11:0] A_CHAN  = `IDX_CHAN_SEL << 2;
	localparam logic [11:0] A_SOF   = `IDX_FRAME_SOF << 2;
	localparam logic [11:0] A_CNT   = `IDX_FRAME_CNT << 2;
	localparam logic [11:0] A_BYTES = `IDX_BYTE_CNT << 2;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr, perr, irq;
	logic        rx_start, rx_valid, rx_ready, en, big, mem_we, fault;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] rx_len, rx_status, rx_data, evt_word, mem_data;
	logic [1:0]  chan;
	logic [23:0] base, mem_addr;
	logic [2:0]  req_seen;
	logic [15:0] mem_img [int];
	int          fail_count, n_tests, wcount, w0, lowc;

	dma_link_if dma_link_if_inst ();
	eth_rx_dma_device #(.P_RAM_WORDS(64), .P_BURST_ON_CYC(40), .P_BURST_OFF_CYC(10))
		eth_rx_dma_device_inst (.i_clock(clock), .i_rstn(rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_start(rx_start),
		.i_rx_len(rx_len), .i_rx_status(rx_status), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .o_rx_ready(rx_ready), .i_rx_event_word(evt_word),
		.o_irq(irq), .link(dma_link_if_inst));
	eth_rx_dma_host eth_rx_dma_host_inst (.i_clock(clock), .i_rstn(rstn), .i_enable(en),
		.i_channel(chan), .i_base(base), .i_big(big), .o_mem_we(mem_we),
		.o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_boundary_fault(fault),
		.link(dma_link_if_inst));
	eth_rx_dma_link_sva eth_rx_dma_link_sva_inst (.i_clock(clock), .i_rstn(rstn),
		.dma_request_pin(dma_link_if_inst.dma_request_pin),
		.dma_acknowledge_pin_n(dma_link_if_inst.dma_acknowledge_pin_n),
		.dma_data(dma_link_if_inst.dma_data));

	// 50 MHz clock
	initial clock = 1'b0;
	always #10 clock = ~clock;

	// Host memory image and request pins ever raised
	always @(posedge clock) begin
		if (mem_we === 1'b1) begin
			mem_img[int'(mem_addr)] = mem_data;
			wcount++;
		end
		req_seen |= dma_link_if_inst.dma_request_pin;
	end

	task automatic summarize;
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic give_up;
		fail_count++;
		summarize();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask : check

	// One APB transfer; the slave may stretch the access phase
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t >= 50) give_up();
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask : rd

	// Hands a frame to the receiver; words carry the frame tag and index
	task automatic rx_frame(input logic [15:0] len, input logic [7:0] f);
		int t;
		w0 = wcount;
		rx_start <= 1'b1;
		rx_len <= len;
		rx_status <= {8'h5A, f};
		@(posedge clock);
		rx_start <= 1'b0;
		for (int i = 0; i < (len + 1) / 2; i++) begin
			rx_valid <= 1'b1;
			rx_data <= {f, i[7:0]};
			t = 0;
			do begin
				@(posedge clock);
				t++;
			end while (rx_ready !== 1'b1 && t < 50);
			if (t >= 50) give_up();
		end
		rx_valid <= 1'b0;
		@(posedge clock);
	endtask : rx_frame

	// Waits for n host memory writes, counting cycles with no request
	task automatic wait_words(input int n);
		int t;
		t = 0;
		lowc = 0;
		while (wcount < w0 + n && t < 3000) begin
			@(posedge clock);
			t++;
			if (dma_link_if_inst.dma_request_pin === 3'b000) lowc++;
		end
		if (t >= 3000) give_up();
		repeat (2) @(posedge clock);
	endtask : wait_words

	// Main sequence
	initial begin
		{psel, penable, pwrite, rx_start, rx_valid, big, rstn} = '0;
		paddr = '0;
		pwdata = '0;
		{rx_len, rx_status, rx_data} = '0;
		evt_word = 16'h1234;
		en = 1'b1;
		chan = 2'd1;
		base = BASE;
		{fail_count, n_tests, wcount, w0, lowc} = '0;
		req_seen = '0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(A_CHAN, 0);
		rd(A_SOF, 0);
		rd(A_CNT, 0);
		rd(A_BYTES, 0);
		apb(1'b0, 12'hFFC, 32'h0);
		check(perr, 1'b1);
		check(fault, 1'b0);
		base <= 24'h01FF00;
		@(posedge clock);
		check(fault, 1'b1);
		base <= BASE;
		wr(A_CHAN, 16'h0001);
		rd(A_REVT, 16'h1234);
		// Auto-switch alone leaves the frame on chip
		wr(A_RCFG, 16'h0400);
		rx_frame(16'd5, 8'h01);
		repeat (30) @(posedge clock);
		check(dma_link_if_inst.dma_request_pin, 3'b000);
		wr(A_RCFG, 16'h0600);
		wait_words(6);
		rd(A_REVT, 0);
		check(mem_img[BASE], 16'h5A01);
		check(mem_img[BASE + 2], 16'h0005);
		check(mem_img[BASE + 8], 16'h0102);
		rd(A_BEVT, 16'h0080);
		rd(A_BEVT, 16'h0080);
		check(irq, 1'b0);
		wr(A_BCFG, 16'h0080);
		check(irq, 1'b1);
		rd(A_SOF, 0);
		rd(A_BYTES, 12);
		rd(A_CNT, 1);
		rd(A_BEVT, 0);
		check(irq, 1'b0);
		rd(A_CNT, 0);
		// Second frame starts on the next double word
		rx_frame(16'd4, 8'h02);
		wait_words(4);
		check(lowc < 10, 1'b1);
		rd(A_SOF, 20'd12);
		rd(A_BYTES, 8);
		check(mem_img[BASE + 12], 16'h5A02);
		rd(A_CNT, 1);
		rd(A_CNT, 0);
		// Channel 3 holds frames back until the on-chip RAM overflows
		wr(A_CHAN, 16'h0003);
		rx_frame(16'd100, 8'h03);
		rx_frame(16'd100, 8'h04);
		repeat (20) @(posedge clock);
		check(req_seen, 3'b010);
		rd(A_MISS, 1);
		rd(A_MISS, 0);
		wr(A_BUS, 16'h0800);
		wr(A_CHAN, 16'h0001);
		wait_words(52);
		check(lowc > 20, 1'b1);
		rd(A_SOF, 20);
		rd(A_BYTES, 104);
		check(mem_img[BASE + 20], 16'h5A03);
		rd(A_CNT, 1);
		rd(A_CNT, 0);
		// DMA reset returns the write offset to zero
		wr(A_BUS, 16'h0040);
		rd(A_BUS, 0);
		en <= 1'b0;
		@(posedge clock);
		en <= 1'b1;
		rx_frame(16'd4, 8'h05);
		wait_words(4);
		rd(A_SOF, 0);
		check(mem_img[BASE], 16'h5A05);
		rd(A_RCFG, 16'h0600);
		// Commit, release by reset, then fill the 16K ring once round
		rd(A_CNT, 1);
		wr(A_BUS, 16'h0040);
		en <= 1'b0;
		@(posedge clock);
		en <= 1'b1;
		// Frame 0 committed, freed by implied skip; frames 1-2 committed again
		for (int k = 0; k < 258; k++) begin
			rx_frame(16'd60, k[7:0]);
			if (k < 257) wait_words(32);
			if (k == 0) rd(A_CNT, 1);
			if (k == 1) rd(A_BEVT, 16'h0080);
			if (k == 2) rd(A_CNT, 2);
		end
		// Last frame would land on committed space and must wait
		repeat (200) @(posedge clock);
		check(wcount, w0);
		rd(A_CNT, 254);
		wait_words(32);
		check(mem_img[BASE + 16320], 16'h5AFF);
		check(mem_img[BASE], 16'h5A00);
		check(mem_img[BASE + 64], 16'h5A01);
		rd(A_SOF, 16'h0040);
		rd(A_CNT, 1);
		// 64K ring: the same traffic no longer wraps at 16K
		wr(A_BUS, 16'h2040);
		big <= 1'b1;
		en <= 1'b0;
		@(posedge clock);
		en <= 1'b1;
		for (int k = 0; k < 257; k++) begin
			rx_frame(16'd60, k[7:0]);
			wait_words(32);
		end
		rd(A_SOF, 16'h4000);
		check(mem_img[BASE + 16384], 16'h5A00);
		rd(A_CNT, 257);
		summarize();
	end
endmodule : ethernet_receive_slave_dma_tb
